// ### msimr_pkg.sv
// package: register map, field layout and constants of the msi message registers
package msimr_pkg;
	localparam int ADDR_W = 8;
	// register byte offsets
	localparam logic [7:0] OFF_MSI_CTRL = 8'hd0;
	localparam logic [7:0] OFF_MSI_LOW_ADDRESS = 8'hd4;
	localparam logic [7:0] OFF_MSI_HIGH_ADDRESS = 8'hd8;
	localparam logic [7:0] OFF_MSI_MESSAGE_PAYLOAD = 8'hdc;
	localparam logic [7:0] OFF_SUBSYSTEM_CAP_HEADER = 8'hf0;
	localparam logic [7:0] OFF_SUBSYSTEM_IDENTIFIERS = 8'hf4;
	localparam logic [7:0] OFF_LOCK_CTRL = 8'he0;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'he4;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'he8;
	localparam logic [7:0] OFF_IRQ_CLEAR = 8'hec;
	// field layout
	localparam int MSI_EN_BIT = 16;
	localparam int GVC_LSB = 20;
	localparam int GVC_MSB = 22;
	localparam int A64_BIT = 23;
	localparam int NXT_LSB = 8;
	localparam int NXT_MSB = 15;
	localparam int ADDR_LO_LSB = 2;
	// constant values
	localparam logic [7:0] MSI_CAPABILITY_CODE = 8'h05;
	localparam logic [7:0] SUBSYS_CAPABILITY_CODE = 8'h0d;
	localparam logic [7:0] NEXT_CAP_PTR_RESET = 8'h00;
	localparam logic [15:0] SUBSYS_IDENT_RESET = 16'h0000;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	localparam logic [3:0] PAYLOAD_BYTE_EN = 4'h3;
	// interrupt status bit positions
	localparam int IRQ_W = 3;
	localparam int IRQ_SENT = 0;
	localparam int IRQ_DROPPED = 1;
	localparam int IRQ_LOCKED_WR = 2;
	typedef enum logic [1:0] {MSIMR_IDLE, MSIMR_ISSUE} msimr_state_t;
endpackage

// ### msimr_wb_slave.sv
// classic wishbone slave front end: read data capture, single-cycle ack, write strobe
`timescale 1ns/1ps
module msimr_wb_slave (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic cyc, // bus cycle
	input wire logic stb, // strobe
	input wire logic we, // write enable
	input wire logic [msimr_pkg::ADDR_W-1:0] adr, // byte address
	input wire logic [31:0] rd_word, // selected register read data
	output logic ack, // one-cycle acknowledge
	output logic [31:0] dat_o, // registered read data
	output logic wr_pulse // write takes effect this cycle
);
	import msimr_pkg::*;
	logic ack_ff;
	logic [31:0] dat_ff;
	wire req = cyc && stb && !ack_ff;
	// ack one cycle after the request; dropped the cycle after it was given
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_ff <= 1'b0;
			dat_ff <= ZERO32;
		end else begin
			ack_ff <= req;
			dat_ff <= req ? rd_word : dat_ff;
		end
	end
	// write commits on the acking edge, as the master samples ack there
	assign wr_pulse = ack_ff && cyc && stb && we;
	assign ack = ack_ff;
	assign dat_o = dat_ff;
endmodule // msimr_wb_slave

// ### msimr_msg_gen.sv
// forms one msi memory write from the programmed address and payload
`timescale 1ns/1ps
module msimr_msg_gen (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic trig, // message request pulse
	input wire logic msi_en, // msi enable
	input wire logic [29:0] addr_low, // dword address low part
	input wire logic [31:0] addr_high, // upper address
	input wire logic [15:0] payload, // message data value
	input wire logic out_ready, // upstream port accepts
	output logic out_valid, // write request valid
	output logic [63:0] out_addr, // write address
	output logic out_is64, // 64-bit address format
	output logic [31:0] out_data, // write payload
	output logic [3:0] out_be, // byte enables
	output logic sent, // pulse: write accepted
	output logic dropped // pulse: trigger refused
);
	import msimr_pkg::*;
	msimr_state_t state_ff, nxt_state;
	logic [63:0] addr_ff;
	logic is64_ff;
	logic valid_ff;
	logic [31:0] data_ff;
	wire accept = trig && msi_en && (state_ff == MSIMR_IDLE);
	wire wide = (addr_high != ZERO32);
	wire [63:0] form_addr = wide ? {addr_high, addr_low, 2'b00} : {ZERO32, addr_low, 2'b00};
	// payload is never offset by a vector number: one vector only
	wire [31:0] form_data = {16'h0000, payload};
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			MSIMR_IDLE: nxt_state = accept ? MSIMR_ISSUE : MSIMR_IDLE;
			MSIMR_ISSUE: nxt_state = out_ready ? MSIMR_IDLE : MSIMR_ISSUE;
			default: nxt_state = MSIMR_IDLE;
		endcase
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= MSIMR_IDLE;
			addr_ff <= 64'h0;
			is64_ff <= 1'b0;
			valid_ff <= 1'b0;
			data_ff <= ZERO32;
		end else begin
			state_ff <= nxt_state;
			valid_ff <= (nxt_state == MSIMR_ISSUE);
			if (accept) begin
				addr_ff <= form_addr;
				is64_ff <= wide;
				data_ff <= form_data;
			end
		end
	end
	// valid straight from its own flop, mirrors the issue state
	assign out_valid = valid_ff;
	assign out_addr = addr_ff;
	assign out_is64 = is64_ff;
	assign out_data = data_ff;
	assign out_be = PAYLOAD_BYTE_EN;
	assign sent = out_valid && out_ready;
	assign dropped = trig && !accept;
endmodule // msimr_msg_gen

// ### msimr_regs.sv
// msi message address/data and subsystem identification register bank
// Function
// - writable dword-aligned low message address in 31:2; bits 1:0 read zero.
// - writable upper address; non-zero selects a 64-bit message write address.
// - zero upper address gives a 32-bit write from the low address only.
// - every message write leaves via the upstream port, whatever its address.
// - writable 16-bit message data in 15:0 is the payload low half; 31:16 zero.
// - subsystem capability header returns read-only code 0xd in 7:0.
// - header 15:8 holds lockable next pointer; 31:16 read zero.
// - identifier 15:0 holds lockable subsystem vendor id, reset zero.
// - identifier 31:16 holds lockable subsystem id, reset zero.
// - message writes are generated only while msi enable bit 16 is set.
// - vector count fixed to one message; payload never altered by vector.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
module msimr_regs (
	input wire logic SYS_CLK, // 125 MHz system clock
	input wire logic RST, // async reset, active high
	input wire logic WB_CYC_I, // wishbone cycle
	input wire logic WB_STB_I, // wishbone strobe
	input wire logic WB_WE_I, // wishbone write enable
	input wire logic [msimr_pkg::ADDR_W-1:0] WB_ADR_I, // byte address
	input wire logic [3:0] WB_SEL_I, // byte lane selects
	input wire logic [31:0] WB_DAT_I, // write data
	input wire logic MSG_TRIG, // pulse: request one message
	input wire logic UP_READY, // upstream port accepts write
	output logic WB_ACK_O, // wishbone acknowledge
	output logic [31:0] WB_DAT_O, // read data
	output logic UP_VALID, // message write valid toward upstream port
	output logic [63:0] UP_ADDR, // message write address
	output logic UP_IS64, // 64-bit address format
	output logic [31:0] UP_DATA, // message payload
	output logic [3:0] UP_BE, // payload byte enables
	output logic IRQ // level interrupt
);
	import msimr_pkg::*;
	logic [29:0] msi_low_address_ff;
	logic [31:0] msi_high_address_ff;
	logic [15:0] msg_payload_value_ff;
	logic msi_en_ff;
	logic [7:0] next_cap_pointer_ff;
	logic [15:0] subsys_vendor_ident_ff;
	logic [15:0] subsys_ident_ff;
	logic lock_ff;
	logic [IRQ_W-1:0] irq_status_ff, nxt_irq_status;
	logic [IRQ_W-1:0] irq_enable_ff;
	logic irq_ff;
	logic [31:0] rd_word;
	logic wr_pulse;
	logic sent;
	logic dropped;
	wire [31:0] wmask;
	// byte-lane mask from sel
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wmask[gi*8 +: 8] = {8{WB_SEL_I[gi]}};
		end
	endgenerate
	wire hit_ctrl = (WB_ADR_I == OFF_MSI_CTRL);
	wire hit_lo = (WB_ADR_I == OFF_MSI_LOW_ADDRESS);
	wire hit_hi = (WB_ADR_I == OFF_MSI_HIGH_ADDRESS);
	wire hit_pl = (WB_ADR_I == OFF_MSI_MESSAGE_PAYLOAD);
	wire hit_cap = (WB_ADR_I == OFF_SUBSYSTEM_CAP_HEADER);
	wire hit_sid = (WB_ADR_I == OFF_SUBSYSTEM_IDENTIFIERS);
	wire hit_lock = (WB_ADR_I == OFF_LOCK_CTRL);
	wire hit_ist = (WB_ADR_I == OFF_IRQ_STATUS);
	wire hit_ien = (WB_ADR_I == OFF_IRQ_ENABLE);
	wire hit_iclr = (WB_ADR_I == OFF_IRQ_CLEAR);
	// merged write values per register
	wire [31:0] lo_word = {msi_low_address_ff, 2'b00};
	wire [31:0] lo_new = (lo_word & ~wmask) | (WB_DAT_I & wmask);
	wire [31:0] hi_new = (msi_high_address_ff & ~wmask) | (WB_DAT_I & wmask);
	wire [31:0] pl_word = {16'h0000, msg_payload_value_ff};
	wire [31:0] pl_new = (pl_word & ~wmask) | (WB_DAT_I & wmask);
	wire [31:0] cap_word = {16'h0000, next_cap_pointer_ff, SUBSYS_CAPABILITY_CODE};
	wire [31:0] cap_new = (cap_word & ~wmask) | (WB_DAT_I & wmask);
	wire [31:0] sid_word = {subsys_ident_ff, subsys_vendor_ident_ff};
	wire [31:0] sid_new = (sid_word & ~wmask) | (WB_DAT_I & wmask);
	wire [31:0] ctrl_word = {8'h00, 1'b1, 3'b000, 3'b000, msi_en_ff, NEXT_CAP_PTR_RESET, MSI_CAPABILITY_CODE};
	// lockable fields take writes only while the lock is open
	wire wr_locked = wr_pulse && lock_ff && (hit_cap || hit_sid);
	wire wr_open = wr_pulse && !lock_ff;
	// read mux; unmapped offsets read zero and still ack
	assign rd_word = hit_ctrl ? ctrl_word :
		hit_lo ? lo_word :
		hit_hi ? msi_high_address_ff :
		hit_pl ? pl_word :
		hit_cap ? cap_word :
		hit_sid ? sid_word :
		hit_lock ? {31'h0, lock_ff} :
		hit_ist ? {29'h0, irq_status_ff} :
		hit_ien ? {29'h0, irq_enable_ff} : ZERO32;
	msimr_wb_slave u_bus (
		.clk(SYS_CLK),
		.rst(RST),
		.cyc(WB_CYC_I),
		.stb(WB_STB_I),
		.we(WB_WE_I),
		.adr(WB_ADR_I),
		.rd_word(rd_word),
		.ack(WB_ACK_O),
		.dat_o(WB_DAT_O),
		.wr_pulse(wr_pulse)
	);
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			msi_low_address_ff <= 30'h0;
			msi_high_address_ff <= ZERO32;
			msg_payload_value_ff <= 16'h0000;
			msi_en_ff <= 1'b0;
		end else if (wr_pulse) begin
			if (hit_lo)
				msi_low_address_ff <= lo_new[31:ADDR_LO_LSB];
			if (hit_hi)
				msi_high_address_ff <= hi_new;
			if (hit_pl)
				msg_payload_value_ff <= pl_new[15:0];
			if (hit_ctrl && WB_SEL_I[2])
				msi_en_ff <= WB_DAT_I[MSI_EN_BIT];
		end
	end
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			next_cap_pointer_ff <= NEXT_CAP_PTR_RESET;
			subsys_vendor_ident_ff <= SUBSYS_IDENT_RESET;
			subsys_ident_ff <= SUBSYS_IDENT_RESET;
			lock_ff <= 1'b0;
		end else begin
			if (wr_open && hit_cap)
				next_cap_pointer_ff <= cap_new[NXT_MSB:NXT_LSB];
			if (wr_open && hit_sid) begin
				subsys_vendor_ident_ff <= sid_new[15:0];
				subsys_ident_ff <= sid_new[31:16];
			end
			// lock is set-only until reset, as a boot loader would leave it
			if (wr_pulse && hit_lock && WB_SEL_I[0] && WB_DAT_I[0])
				lock_ff <= 1'b1;
		end
	end
	// all messages leave on the one upstream port; no address decode here
	msimr_msg_gen u_gen (
		.clk(SYS_CLK),
		.rst(RST),
		.trig(MSG_TRIG),
		.msi_en(msi_en_ff),
		.addr_low(msi_low_address_ff),
		.addr_high(msi_high_address_ff),
		.payload(msg_payload_value_ff),
		.out_ready(UP_READY),
		.out_valid(UP_VALID),
		.out_addr(UP_ADDR),
		.out_is64(UP_IS64),
		.out_data(UP_DATA),
		.out_be(UP_BE),
		.sent(sent),
		.dropped(dropped)
	);
	// sticky status: set wins over a clear in the same cycle
	wire [IRQ_W-1:0] ev_set = {wr_locked, dropped, sent};
	wire [IRQ_W-1:0] ev_clr = (wr_pulse && hit_iclr && WB_SEL_I[0]) ? WB_DAT_I[IRQ_W-1:0] : {IRQ_W{1'b0}};
	// irq follows an enable write on the same edge, not one cycle behind it
	wire [IRQ_W-1:0] nxt_irq_enable = (wr_pulse && hit_ien && WB_SEL_I[0]) ? WB_DAT_I[IRQ_W-1:0] : irq_enable_ff;
	assign nxt_irq_status = (irq_status_ff & ~ev_clr) | ev_set;
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			irq_status_ff <= {IRQ_W{1'b0}};
			irq_enable_ff <= {IRQ_W{1'b0}};
			irq_ff <= 1'b0;
		end else begin
			irq_status_ff <= nxt_irq_status;
			irq_enable_ff <= nxt_irq_enable;
			irq_ff <= |(nxt_irq_status & nxt_irq_enable);
		end
	end
	assign IRQ = irq_ff;
endmodule // msimr_regs

// ### msimr_regs_assertions.sv
// checker: bus answer, read-back and message port checks of msimr_regs
`timescale 1ns/1ps
module msimr_regs_assertions (
	input wire logic SYS_CLK, // clock
	input wire logic RST, // reset
	input wire logic WB_CYC_I, // cycle
	input wire logic WB_STB_I, // strobe
	input wire logic WB_WE_I, // write
	input wire logic [msimr_pkg::ADDR_W-1:0] WB_ADR_I, // address
	input wire logic WB_ACK_O, // ack
	input wire logic [31:0] WB_DAT_O, // read data
	input wire logic UP_READY, // accept
	input wire logic UP_VALID, // valid
	input wire logic [63:0] UP_ADDR, // address
	input wire logic UP_IS64, // format
	input wire logic [31:0] UP_DATA, // payload
	input wire logic [3:0] UP_BE // lanes
);
	import msimr_pkg::*;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	wire rd_req = WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O;
	a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
	a_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
	a_low_align: assert property (rd_req && WB_ADR_I == OFF_MSI_LOW_ADDRESS |=> WB_DAT_O[1:0] == 2'h0)
		else $error("low address bits set");
	a_data_rsvd: assert property (rd_req && WB_ADR_I == OFF_MSI_MESSAGE_PAYLOAD |=> WB_DAT_O[31:16] == 16'h0)
		else $error("payload upper set");
	a_cap_code: assert property (rd_req && WB_ADR_I == OFF_SUBSYSTEM_CAP_HEADER |=>
		WB_DAT_O[7:0] == 8'h0d && WB_DAT_O[31:16] == 16'h0) else $error("bad header");
	a_fmt_narrow: assert property (UP_VALID && !UP_IS64 |-> UP_ADDR[63:32] == 32'h0) else $error("narrow addr");
	a_fmt_wide: assert property (UP_VALID && UP_IS64 |-> UP_ADDR[63:32] != 32'h0) else $error("wide addr");
	a_msg_hold: assert property (UP_VALID && !UP_READY |=> UP_VALID && $stable(UP_ADDR) && $stable(UP_DATA))
		else $error("write not held");
	a_pay_upper: assert property (UP_VALID |-> UP_DATA[31:16] == 16'h0 && UP_BE == 4'h3 && UP_ADDR[1:0] == 2'h0)
		else $error("bad payload");
endmodule // msimr_regs_assertions
bind msimr_regs msimr_regs_assertions chk_u (.SYS_CLK(SYS_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O),
	.UP_READY(UP_READY), .UP_VALID(UP_VALID), .UP_ADDR(UP_ADDR), .UP_IS64(UP_IS64), .UP_DATA(UP_DATA),
	.UP_BE(UP_BE));

// ### msimr_root_model.sv
// model of the root side: takes message writes after a set stall
`timescale 1ns/1ps
module msimr_root_model (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic valid, // write offered
	input wire logic [63:0] addr, // write address
	input wire logic [31:0] data, // payload
	input wire logic [3:0] stall, // cycles held off
	output logic ready, // write taken
	output logic [63:0] last_addr, // last address taken
	output logic [31:0] last_data, // last payload taken
	output int n_got // writes taken
);
	logic [3:0] wait_ff;
	assign ready = valid && wait_ff >= stall;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_ff <= 4'h0;
			n_got <= 0;
			last_addr <= 64'h0;
			last_data <= 32'h0;
		end else if (ready) begin
			wait_ff <= 4'h0;
			n_got <= n_got + 1;
			last_addr <= addr;
			last_data <= data;
		end else if (valid)
			wait_ff <= wait_ff + 4'h1;
	end
endmodule // msimr_root_model

// ### msimr_regs_tb.sv
// self-checking bench of the msi message register bank
`timescale 1ns/1ps
module msimr_regs_tb;
	import msimr_pkg::*;
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, trig = 0, ack, valid, is64, irq, ready;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, up_data, last_data, q;
	logic [3:0] sel = 4'hf, stall = 4'h0, be;
	logic [63:0] up_addr, last_addr;
	int failures = 0, n_checks = 0, n_got;
	msimr_regs dut_u (.SYS_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(wdat), .MSG_TRIG(trig), .UP_READY(ready), .WB_ACK_O(ack), .WB_DAT_O(rdat),
		.UP_VALID(valid), .UP_ADDR(up_addr), .UP_IS64(is64), .UP_DATA(up_data), .UP_BE(be), .IRQ(irq));
	msimr_root_model root_u (.clk(clk), .rst(rst), .valid(valid), .addr(up_addr), .data(up_data),
		.stall(stall), .ready(ready), .last_addr(last_addr), .last_data(last_data), .n_got(n_got));
	initial forever #4 clk = ~clk;
	task end_sim;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// called just after an edge; returns after the idle cycle
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		i = 0;
		@(posedge clk);
		while (ack !== 1'b1 && i < 20) begin
			@(posedge clk);
			i++;
		end
		if (i >= 20) failures++;
		q = rdat;
		cyc <= 0;
		stb <= 0;
		@(posedge clk);
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		wb(0, a, 32'h0);
		chk(q, exp);
	endtask
	// holds the trigger for k edges, then waits for the root to take one write
	task fire(input int k);
		int i, n0;
		n0 = n_got;
		trig <= 1;
		repeat (k) @(posedge clk);
		trig <= 0;
		i = 0;
		while (n_got == n0 && i < 40) begin
			@(posedge clk);
			i++;
		end
		if (i >= 40) failures++;
	endtask
	task t_reset;
		rd_chk(OFF_MSI_LOW_ADDRESS, 32'h0);
		rd_chk(OFF_MSI_HIGH_ADDRESS, 32'h0);
		rd_chk(OFF_MSI_MESSAGE_PAYLOAD, 32'h0);
		rd_chk(OFF_SUBSYSTEM_IDENTIFIERS, 32'h0);
		rd_chk(OFF_SUBSYSTEM_CAP_HEADER, {16'h0, NEXT_CAP_PTR_RESET, 8'h0d});
		rd_chk(8'h40, 32'h0);
	endtask
	task t_fields;
		wb(1, OFF_MSI_LOW_ADDRESS, 32'hffff_ffff);
		rd_chk(OFF_MSI_LOW_ADDRESS, 32'hffff_fffc);
		wb(1, OFF_MSI_MESSAGE_PAYLOAD, 32'hffff_ffff);
		rd_chk(OFF_MSI_MESSAGE_PAYLOAD, 32'h0000_ffff);
		wb(1, OFF_SUBSYSTEM_CAP_HEADER, 32'hffff_ffff);
		rd_chk(OFF_SUBSYSTEM_CAP_HEADER, 32'h0000_ff0d);
		wb(1, OFF_SUBSYSTEM_IDENTIFIERS, 32'ha5a5_5a5a);
		rd_chk(OFF_SUBSYSTEM_IDENTIFIERS, 32'ha5a5_5a5a);
		wb(1, 8'h40, 32'hffff_ffff);
		rd_chk(8'h40, 32'h0);
	endtask
	task t_msg;
		wb(1, OFF_MSI_HIGH_ADDRESS, 32'h0);
		wb(1, OFF_MSI_LOW_ADDRESS, 32'h1000_0040);
		wb(1, OFF_MSI_MESSAGE_PAYLOAD, 32'hffff_1234);
		trig <= 1;
		@(posedge clk);
		trig <= 0;
		repeat (3) @(posedge clk);
		chk(valid, 64'h0);
		rd_chk(OFF_IRQ_STATUS, 32'h2);
		wb(1, OFF_MSI_CTRL, 32'h0001_0000);
		fire(1);
		chk(last_addr, 64'h0000_0000_1000_0040);
		chk(last_data, 64'h1234);
		wb(1, OFF_MSI_HIGH_ADDRESS, 32'h0000_00a5);
		stall <= 4'h3;
		fire(2);
		chk(last_addr, 64'h0000_00a5_1000_0040);
		repeat (4) @(posedge clk);
		chk(valid, 64'h0);
		rd_chk(OFF_IRQ_STATUS, 32'h3);
		wb(1, OFF_IRQ_CLEAR, 32'h3);
		rd_chk(OFF_IRQ_STATUS, 32'h0);
	endtask
	task t_irq;
		wb(1, OFF_IRQ_ENABLE, 32'h1);
		wb(1, OFF_LOCK_CTRL, 32'h1);
		wb(1, OFF_SUBSYSTEM_IDENTIFIERS, 32'h1111_1111);
		wb(1, OFF_SUBSYSTEM_CAP_HEADER, 32'h0);
		chk(irq, 64'h0);
		rd_chk(OFF_SUBSYSTEM_IDENTIFIERS, 32'ha5a5_5a5a);
		rd_chk(OFF_SUBSYSTEM_CAP_HEADER, 32'h0000_ff0d);
		wb(1, OFF_IRQ_ENABLE, 32'h4);
		chk(irq, 64'h1);
		wb(1, OFF_IRQ_CLEAR, 32'h4);
		chk(irq, 64'h0);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		t_reset;
		t_fields;
		t_msg;
		t_irq;
		end_sim;
	end
	initial begin
		#100000;
		failures++;
		end_sim;
	end
endmodule // msimr_regs_tb
